// ==== pkg/mac_slice_defs.vh ====
`ifndef MAC_SLICE_DEFS_VH
`define MAC_SLICE_DEFS_VH
// ==========================================================
// operand and result widths
`define W_A        27
`define W_B        18
`define W_P        45
`define W_ACC      48
`define W_WIDE     96
`define W_LANE24   24
`define W_LANE12   12
// ==========================================================
// arithmetic opcodes (alu_op_i)
`define OP_ADD     3'h0
`define OP_SUB     3'h1
`define OP_ACC     3'h2
`define OP_ACCSUB  3'h3
`define OP_LOGIC   3'h4
`define OP_CNTUP   3'h5
`define OP_CNTDN   3'h6
`define OP_LOAD    3'h7
// ==========================================================
// simd split (simd_i)
`define SIMD_ONE48 2'h0
`define SIMD_TWO24 2'h1
`define SIMD_FOUR12 2'h2
// ==========================================================
// logic functions (logic_sel_i), ten of them
`define LF_AND     4'h0
`define LF_OR      4'h1
`define LF_XOR     4'h2
`define LF_NAND    4'h3
`define LF_NOR     4'h4
`define LF_XNOR    4'h5
`define LF_ANDN    4'h6
`define LF_ORN     4'h7
`define LF_NOTX    4'h8
`define LF_PASSX   4'h9
// ==========================================================
// xor segment width (xor_width_i)
`define XW_12      2'h0
`define XW_24      2'h1
`define XW_48      2'h2
`define XW_96      2'h3
// ==========================================================
// reset values
`define RST_ACC    48'h0000_0000_0000
`endif

// ==== logic/pipe_reg.v ====
`include "mac_slice_defs.vh"
// ==========================================================
// optional pipeline register with enable and sync reset
module pipe_reg #(
    parameter WIDTH = 8,
    parameter USE   = 1
) (
    // clock and reset
    input  wire             clk_i,
    input  wire             rst_n_i,
    // control
    input  wire             ce_i,
    input  wire             srst_i,
    // data
    input  wire [WIDTH-1:0] d_i,
    output wire [WIDTH-1:0] q_o
);
    reg [WIDTH-1:0] data_q;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            data_q <= {WIDTH{1'b0}};
        end else if (srst_i) begin
            data_q <= {WIDTH{1'b0}};
        end else if (ce_i) begin
            data_q <= d_i;
        end
    end

    // build-time choice: registered or straight through
    assign q_o = (USE != 0) ? data_q : d_i;
endmodule

// ==== logic/mac_slice.v ====
// Summary of operation
// - a signed 27-bit by 18-bit multiply gives the full 45-bit product.
// - a 48-bit accumulator adds (OP_ACC) or subtracts (OP_ACCSUB) each new x operand to or from its stored value.
// - a run-time bypass sends two 48-bit operands straight to the ALU.
// - the adder runs as two 24-bit or four 12-bit carry-free lanes.
// - instead of arithmetic one of ten bitwise logic functions is chosen.
// - a pre-adder combines two operands ahead of the multiplier.
// - a 96-bit xor reduction works over 12, 24, 48 or 96 bit segments.
// - a match of the 48-bit result with a masked pattern is flagged.
// - pattern detector and logic unit together give 96-bit-wide logic.
// - the accumulator can count up or down by one on each enabled clock.
`include "mac_slice_defs.vh"
module mac_slice #(
    parameter USE_IN_REG  = 1,
    parameter USE_MUL_REG = 1
) (
    // clock and reset
    input  wire                 sys_clk_i,
    input  wire                 reset_n_i,
    // stage enables and synchronous resets
    input  wire                 in_ce_i,
    input  wire                 mul_ce_i,
    input  wire                 out_ce_i,
    input  wire                 in_srst_i,
    input  wire                 mul_srst_i,
    input  wire                 out_srst_i,
    // operands
    input  wire [`W_A-1:0]      a_i,
    input  wire [`W_A-1:0]      d_i,
    input  wire [`W_B-1:0]      b_i,
    input  wire [`W_ACC-1:0]    x_i,
    input  wire [`W_ACC-1:0]    y_i,
    input  wire [`W_ACC-1:0]    pattern_i,
    input  wire [`W_ACC-1:0]    mask_i,
    // run-time control
    input  wire                 preadd_en_i,
    input  wire                 preadd_sub_i,
    input  wire                 mul_bypass_i,
    input  wire [2:0]           alu_op_i,
    input  wire [1:0]           simd_i,
    input  wire [3:0]           logic_sel_i,
    input  wire [1:0]           xor_width_i,
    input  wire                 wide_logic_i,
    // results
    output reg  [`W_ACC-1:0]    result_o,
    output reg  [3:0]           carry_o,
    output reg  [7:0]           xor_o,
    output reg                  pattern_match_o,
    output reg                  pattern_bmatch_o,
    output reg                  wide_match_o
);
    // ==========================================================
    // reset release
    reg rst_meta_q;
    reg rst_sync_q;

    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // ==========================================================
    // input stage
    localparam IN_W = 2 * `W_A + `W_B + 2 * `W_ACC + 2;
    wire [IN_W-1:0] in_d = {a_i, d_i, b_i, x_i, y_i,
                            preadd_en_i, preadd_sub_i};
    wire [IN_W-1:0] in_q;

    pipe_reg #(.WIDTH(IN_W), .USE(USE_IN_REG)) u_in_reg (
        .clk_i   (sys_clk_i),
        .rst_n_i (rst_sync_q),
        .ce_i    (in_ce_i),
        .srst_i  (in_srst_i),
        .d_i     (in_d),
        .q_o     (in_q)
    );

    wire [`W_A-1:0]   a_s  = in_q[IN_W-1 -: `W_A];
    wire [`W_A-1:0]   d_s  = in_q[IN_W-1-`W_A -: `W_A];
    wire [`W_B-1:0]   b_s  = in_q[2*`W_ACC+2+`W_B-1 -: `W_B];
    wire [`W_ACC-1:0] x_s  = in_q[2*`W_ACC+1 -: `W_ACC];
    wire [`W_ACC-1:0] y_s  = in_q[`W_ACC+1 -: `W_ACC];
    wire              pa_en  = in_q[1];
    wire              pa_sub = in_q[0];

    // ==========================================================
    // pre-adder and multiplier
    // the pre-adder wraps at 27 bits; callers keep operands in range
    reg  [`W_A-1:0] pre_sum;
    always @* begin
        if (!pa_en) begin
            pre_sum = a_s;
        end else if (pa_sub) begin
            pre_sum = d_s - a_s;
        end else begin
            pre_sum = d_s + a_s;
        end
    end

    wire signed [`W_A-1:0] mul_a = pre_sum;
    wire signed [`W_B-1:0] mul_b = b_s;
    wire signed [`W_P-1:0] product = mul_a * mul_b;

    wire [`W_P-1:0] prod_q;
    pipe_reg #(.WIDTH(`W_P), .USE(USE_MUL_REG)) u_mul_reg (
        .clk_i   (sys_clk_i),
        .rst_n_i (rst_sync_q),
        .ce_i    (mul_ce_i),
        .srst_i  (mul_srst_i),
        .d_i     (product),
        .q_o     (prod_q)
    );

    // ==========================================================
    // operand select
    reg  [`W_ACC-1:0] acc_q;
    wire [`W_ACC-1:0] prod_ext = {{(`W_ACC-`W_P){prod_q[`W_P-1]}}, prod_q};
    // bypass feeds x directly; y is always the second operand
    wire [`W_ACC-1:0] opx = mul_bypass_i ? x_s : prod_ext;
    wire [`W_ACC-1:0] opy = y_s;

    // ==========================================================
    // lane-split adder: carries are cut at lane boundaries
    reg  [`W_ACC-1:0] addl;
    reg  [`W_ACC-1:0] addr;
    reg               sub;
    reg  [`W_ACC-1:0] sum;
    reg  [3:0]        cout;
    reg  [12:0]       s12;
    reg  [24:0]       s24;
    reg  [48:0]       s48;
    integer           k;

    always @* begin
        addl = opy;
        addr = opx;
        sub  = 1'b0;
        case (alu_op_i)
            `OP_SUB:    sub  = 1'b1;
            `OP_ACC:    addl = acc_q;
            `OP_ACCSUB: begin
                addl = acc_q;
                sub  = 1'b1;
            end
            default:    addl = opy;
        endcase
        sum  = {`W_ACC{1'b0}};
        cout = 4'h0;
        s12  = 13'h0000;
        s24  = 25'h0000000;
        s48  = 49'h0;
        case (simd_i)
            `SIMD_TWO24: begin
                for (k = 0; k < 2; k = k + 1) begin
                    s24 = {1'b0, addl[k*24 +: 24]}
                        + {1'b0, addr[k*24 +: 24] ^ {24{sub}}}
                        + {24'h000000, sub};
                    sum[k*24 +: 24] = s24[23:0];
                    cout[k*2+1]     = s24[24];
                end
            end
            `SIMD_FOUR12: begin
                for (k = 0; k < 4; k = k + 1) begin
                    s12 = {1'b0, addl[k*12 +: 12]}
                        + {1'b0, addr[k*12 +: 12] ^ {12{sub}}}
                        + {12'h000, sub};
                    sum[k*12 +: 12] = s12[11:0];
                    cout[k]         = s12[12];
                end
            end
            default: begin
                s48 = {1'b0, addl} + {1'b0, addr ^ {`W_ACC{sub}}}
                    + {48'h0, sub};
                sum     = s48[47:0];
                cout[3] = s48[48];
            end
        endcase
    end

    // ==========================================================
    // logic unit
    reg [`W_ACC-1:0] lres;
    always @* begin
        case (logic_sel_i)
            `LF_AND:   lres = opx & opy;
            `LF_OR:    lres = opx | opy;
            `LF_XOR:   lres = opx ^ opy;
            `LF_NAND:  lres = ~(opx & opy);
            `LF_NOR:   lres = ~(opx | opy);
            `LF_XNOR:  lres = ~(opx ^ opy);
            `LF_ANDN:  lres = opx & ~opy;
            `LF_ORN:   lres = opx | ~opy;
            `LF_NOTX:  lres = ~opx;
            `LF_PASSX: lres = opx;
            default:   lres = {`W_ACC{1'b0}};
        endcase
    end

    // ==========================================================
    // result select and accumulator
    reg [`W_ACC-1:0] acc_d;
    always @* begin
        case (alu_op_i)
            `OP_LOGIC: acc_d = lres;
            `OP_CNTUP: acc_d = acc_q + 48'h0000_0000_0001;
            `OP_CNTDN: acc_d = acc_q - 48'h0000_0000_0001;
            `OP_LOAD:  acc_d = opx;
            default:   acc_d = sum;
        endcase
    end

    // ==========================================================
    // wide xor: 96 bits from the two operands, per-segment parity
    wire [`W_WIDE-1:0] wide = {opy, opx};
    reg  [7:0]         xr;
    integer            j;
    always @* begin
        xr = 8'h00;
        for (j = 0; j < 8; j = j + 1) begin
            xr[0] = (j == 0) ? ^wide[11:0] : xr[0];
        end
        case (xor_width_i)
            `XW_12: begin
                for (j = 0; j < 8; j = j + 1) begin
                    xr[j] = ^wide[j*12 +: 12];
                end
            end
            `XW_24: begin
                for (j = 0; j < 4; j = j + 1) begin
                    xr[j] = ^wide[j*24 +: 24];
                end
            end
            `XW_48: begin
                xr[0] = ^wide[47:0];
                xr[1] = ^wide[95:48];
            end
            default: xr[0] = ^wide;
        endcase
    end

    // ==========================================================
    // pattern detect on the next result; masked bits are ignored
    wire match_d  = &(~(acc_d ^ pattern_i) | mask_i);
    wire bmatch_d = &(~(acc_d ^ ~pattern_i) | mask_i);
    // 96-bit function: result matches the pattern and the logic result
    // equals opx ^ opy under the mask, chaining two 48-bit compares
    wire wide_d   = match_d
                  & (&(~(lres ^ (opx ^ opy)) | mask_i));

    // ==========================================================
    // output stage, always registered so outputs come from flops
    always @(posedge sys_clk_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            acc_q            <= `RST_ACC;
            result_o         <= `RST_ACC;
            carry_o          <= 4'h0;
            xor_o            <= 8'h00;
            pattern_match_o  <= 1'b0;
            pattern_bmatch_o <= 1'b0;
            wide_match_o     <= 1'b0;
        end else if (out_srst_i) begin
            acc_q            <= `RST_ACC;
            result_o         <= `RST_ACC;
            carry_o          <= 4'h0;
            xor_o            <= 8'h00;
            pattern_match_o  <= 1'b0;
            pattern_bmatch_o <= 1'b0;
            wide_match_o     <= 1'b0;
        end else if (out_ce_i) begin
            acc_q            <= acc_d;
            result_o         <= acc_d;
            carry_o          <= cout;
            xor_o            <= xr;
            pattern_match_o  <= match_d;
            pattern_bmatch_o <= bmatch_d;
            wide_match_o     <= wide_d & wide_logic_i;
        end
    end
endmodule

// ==== testbench/fabric_src.sv ====
// =====================================
// operand source standing for the fabric
module fabric_src (
    // clock
    input  wire        sys_clk_i,
    // load request and new operands
    input  wire        load_i,
    input  wire [26:0] a_i,
    input  wire [26:0] d_i,
    input  wire [17:0] b_i,
    input  wire [47:0] x_i,
    input  wire [47:0] y_i,
    // operands towards the slice
    output reg  [26:0] a_o,
    output reg  [26:0] d_o,
    output reg  [17:0] b_o,
    output reg  [47:0] x_o,
    output reg  [47:0] y_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // operands hold between loads, as fabric registers would
    always @(posedge sys_clk_i) begin
        if (load_i) begin
            a_o <= a_i;
            d_o <= d_i;
            b_o <= b_i;
            x_o <= x_i;
            y_o <= y_i;
        end
    end
endmodule

// ==== testbench/mac_slice_checker.sv ====
`include "mac_slice_defs.vh"
// =====================================
// port checks of the slice
module mac_slice_checker #(
    parameter USE_IN_REG = 1
) (
    input wire          sys_clk_i,
    input wire          reset_n_i,
    input wire          in_ce_i,
    input wire          in_srst_i,
    input wire          out_ce_i,
    input wire          out_srst_i,
    input wire [47:0]   x_i,
    input wire [47:0]   y_i,
    input wire [47:0]   pattern_i,
    input wire [47:0]   mask_i,
    input wire          mul_bypass_i,
    input wire [2:0]    alu_op_i,
    input wire [1:0]    simd_i,
    input wire [1:0]    xor_width_i,
    input wire          wide_logic_i,
    input wire [47:0]   result_o,
    input wire [7:0]    xor_o,
    input wire          pattern_match_o,
    input wire          pattern_bmatch_o,
    input wire          wide_match_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    wire fire = out_ce_i && !out_srst_i;
    wire byp2 = mul_bypass_i && USE_IN_REG == 1;
    sequence s_in; in_ce_i && !in_srst_i; endsequence
    AST_FREEZE: assert property (!out_ce_i && !out_srst_i |=>
        $stable(result_o) && $stable(xor_o)) else $error("held out moved");
    AST_SRST: assert property (out_srst_i |=> result_o == 48'h0
        && xor_o == 8'h0) else $error("clear failed");
    AST_CNTUP: assert property (fire && alu_op_i == `OP_CNTUP |=>
        result_o == $past(result_o) + 48'h1) else $error("count up");
    AST_CNTDN: assert property (fire && alu_op_i == `OP_CNTDN |=>
        result_o == $past(result_o) - 48'h1) else $error("count down");
    AST_LOAD: assert property (s_in ##1 fire && byp2 &&
        alu_op_i == `OP_LOAD |=> result_o == $past(x_i, 2))
        else $error("bypass load");
    AST_ACC: assert property (s_in ##1 fire && byp2 &&
        alu_op_i == `OP_ACC && simd_i == `SIMD_ONE48 |=>
        result_o == $past(result_o) + $past(x_i, 2)) else $error("acc");
    AST_XOR96: assert property (s_in ##1 fire && byp2 &&
        xor_width_i == `XW_96 |=>
        xor_o == {7'h0, ^{$past(y_i, 2), $past(x_i, 2)}})
        else $error("xor 96");
    AST_PAT: assert property (fire |=> pattern_match_o ==
        (((result_o ^ $past(pattern_i)) & ~$past(mask_i)) == 48'h0))
        else $error("pattern match");
    AST_BPAT: assert property (fire |=> pattern_bmatch_o ==
        (((result_o ^ ~$past(pattern_i)) & ~$past(mask_i)) == 48'h0))
        else $error("inverse match");
    AST_WIDE: assert property (fire ##1 wide_match_o |->
        pattern_match_o && $past(wide_logic_i)) else $error("wide");
    cover property (fire && alu_op_i == `OP_CNTUP);
    cover property (fire ##1 pattern_match_o);
    cover property (fire ##1 wide_match_o);
    cover property (out_srst_i && out_ce_i);
endmodule
bind mac_slice mac_slice_checker #(.USE_IN_REG(USE_IN_REG)) u_chk (
    .sys_clk_i, .reset_n_i, .in_ce_i, .in_srst_i, .out_ce_i,
    .out_srst_i, .x_i, .y_i, .pattern_i, .mask_i, .mul_bypass_i,
    .alu_op_i, .simd_i, .xor_width_i, .wide_logic_i, .result_o,
    .xor_o, .pattern_match_o, .pattern_bmatch_o, .wide_match_o);

// ==== testbench/mac_slice_tb_top.sv ====
`include "mac_slice_defs.vh"
module mac_slice_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk_i = 0, reset_n_i = 0, out_ce_i = 0, out_srst_i = 0;
    logic ce = 0, pe = 0, ps = 0, byp = 0, wl = 0, ld = 0;
    logic isr = 0, msr = 0, epm, epb, ewm;
    logic [3:0] ecy;
    logic [2:0] op = 0;
    logic [1:0] sm = 0, xw = 0;
    logic [3:0] ls = 0;
    logic [47:0] pat = 0, msk = 0, acc = 0, ex, ox, x_v, y_v;
    logic [95:0] r1, r2;
    logic signed [26:0] a_v, d_v, pa;
    logic signed [17:0] b_v;
    logic signed [44:0] pr;
    wire [26:0] a_w, d_w;
    wire [17:0] b_w;
    wire [47:0] x_w, y_w, result_o;
    wire [3:0] carry_o;
    wire [7:0] xor_o;
    wire pm, pbm, wm;
    integer seed = 19, n_mismatch = 0, tests_run = 0, i;
    fabric_src u_src (.sys_clk_i(sys_clk_i), .load_i(ld), .a_i(a_v),
        .d_i(d_v), .b_i(b_v), .x_i(x_v), .y_i(y_v), .a_o(a_w),
        .d_o(d_w), .b_o(b_w), .x_o(x_w), .y_o(y_w));
    mac_slice dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .in_ce_i(ce), .mul_ce_i(ce), .out_ce_i(out_ce_i),
        .in_srst_i(isr), .mul_srst_i(msr), .out_srst_i(out_srst_i),
        .a_i(a_w), .d_i(d_w), .b_i(b_w), .x_i(x_w), .y_i(y_w),
        .pattern_i(pat), .mask_i(msk), .preadd_en_i(pe),
        .preadd_sub_i(ps), .mul_bypass_i(byp), .alu_op_i(op),
        .simd_i(sm), .logic_sel_i(ls), .xor_width_i(xw),
        .wide_logic_i(wl), .result_o(result_o), .carry_o(carry_o),
        .xor_o(xor_o), .pattern_match_o(pm), .pattern_bmatch_o(pbm),
        .wide_match_o(wm));
    initial forever #25 sys_clk_i = ~sys_clk_i;
    // =====================================
    // reference model
    function [47:0] f_alu(input [47:0] ac, x, y);
        logic [47:0] m, s;
        integer w, k;
        w = sm == 1 ? 24 : sm == 2 ? 12 : 48;
        f_alu = 0;
        case (op)
            `OP_LOGIC: f_alu = f_lf(x, y);
            `OP_CNTUP: f_alu = ac + 1;
            `OP_CNTDN: f_alu = ac - 1;
            `OP_LOAD: f_alu = x;
            // lanes masked one by one, so no carry leaks across
            default: for (k = 0; k < 48; k += w) begin
                m = ((48'h1 << w) - 1) << k;
                s = (op[1] ? ac : y) & m;
                s = op[0] ? s - (x & m) : s + (x & m);
                f_alu |= s & m;
            end
        endcase
    endfunction
    function [47:0] f_lf(input [47:0] x, y);
        case (ls)
            0: f_lf = x & y;
            1: f_lf = x | y;
            2: f_lf = x ^ y;
            3: f_lf = ~(x & y);
            4: f_lf = ~(x | y);
            5: f_lf = ~(x ^ y);
            6: f_lf = x & ~y;
            7: f_lf = x | ~y;
            8: f_lf = ~x;
            9: f_lf = x;
            default: f_lf = 0;
        endcase
    endfunction
    // lane carry-outs; non-arithmetic ops still show the y + x carries
    function [3:0] f_carry(input [47:0] ac, x, y);
        logic [48:0] t, m;
        logic        sb;
        integer      w, k;
        w = sm == 1 ? 24 : sm == 2 ? 12 : 48;
        sb = op == `OP_SUB || op == `OP_ACCSUB;
        f_carry = 0;
        for (k = 0; k < 48; k += w) begin
            m = (49'h1 << w) - 1;
            t = ((op == `OP_ACC || op == `OP_ACCSUB ? ac : y) >> k) & m;
            t += ((sb ? ~x : x) >> k) & m;
            t += sb;
            f_carry[(k + w) / 12 - 1] = t[w];
        end
    endfunction
    function [7:0] f_xor(input [95:0] v);
        integer j;
        f_xor = 0;
        for (j = 0; j < 96; j++) f_xor[j / (12 << xw)] ^= v[j];
    endfunction
    task chk(input string nm, input [47:0] e, g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // =====================================
    // main sequence
    initial begin
        repeat (2) @(posedge sys_clk_i);
        #1 reset_n_i = 1;
        repeat (3) @(posedge sys_clk_i);
        #1 chk("reset", 48'h0, result_o);
        for (i = 0; i < 60; i++) begin
            @(posedge sys_clk_i) #1;
            r1 = {$random(seed), $random(seed), $random(seed)};
            r2 = {$random(seed), $random(seed), $random(seed)};
            {a_v, d_v, b_v} = r2[71:0];
            {x_v, y_v} = r1;
            {pe, ps, byp, op, sm, wl} = r2[80:72];
            // hand-picked: most negative operands, and every logic code
            if (i == 10) {a_v, b_v, byp} = {27'h4000000, 18'h20000, 1'b0};
            if (i < 10) op = `OP_LOGIC;
            ls = i % 10;
            xw = i[1:0];
            msk = r2[95:48];
            ld = 1;
            ce = 1;
            @(posedge sys_clk_i) #1 ld = 0;
            repeat (3) @(posedge sys_clk_i);
            #1;
            pa = pe ? (ps ? d_v - a_v : d_v + a_v) : a_v;
            pr = pa * b_v;
            ox = byp ? x_v : {{3{pr[44]}}, pr};
            ex = f_alu(acc, ox, y_v);
            // odd tests aim the pattern at the inverse result
            pat = i[0] ? ~ex : ex;
            out_ce_i = 1;
            @(posedge sys_clk_i) #1 out_ce_i = 0;
            epm = ((ex ^ pat) & ~msk) == 48'h0;
            epb = ((ex ^ ~pat) & ~msk) == 48'h0;
            ewm = epm && wl && ((f_lf(ox, y_v) ^ ox ^ y_v) & ~msk) == 48'h0;
            ecy = f_carry(acc, ox, y_v);
            chk("res", ex, result_o);
            chk("xor", {40'h0, f_xor({y_v, ox})}, {40'h0, xor_o});
            chk("carry", {44'h0, ecy}, {44'h0, carry_o});
            chk("match", {47'h0, epm}, {47'h0, pm});
            chk("bmatch", {47'h0, epb}, {47'h0, pbm});
            chk("wide", {47'h0, ewm}, {47'h0, wm});
            acc = ex;
            $display("test %0d done", i);
        end
        @(posedge sys_clk_i) #1 {out_srst_i, out_ce_i} = 2'b11;
        @(posedge sys_clk_i) #1 {out_srst_i, out_ce_i} = 2'b00;
        chk("clear", 48'h0, result_o);
        // clear input and product stages, then add what they hold
        {ce, isr, msr} = 3'b011;
        @(posedge sys_clk_i) #1 {isr, msr, byp, op} = {2'b00, 1'b0, `OP_ADD};
        out_ce_i = 1;
        @(posedge sys_clk_i) #1 out_ce_i = 0;
        chk("stage clear", 48'h0, result_o);
        report_and_stop;
    end
    initial begin
        #200000;
        n_mismatch++;
        report_and_stop;
    end
endmodule
